// file: cit_map.vh
`ifndef CIT_MAP_VH
`define CIT_MAP_VH

// ****************************************************************
// Register port word addresses
// ****************************************************************
`define CIT_REG_ENABLE    4'h0
`define CIT_REG_EVENT     4'h1
`define CIT_REG_EVMASK    4'h2
`define CIT_REG_STATE     4'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define CIT_ENABLE_RST    15'h0000
`define CIT_EVMASK_RST    5'h00

// ****************************************************************
// Event bit positions and field width
// ****************************************************************
`define CIT_EV_EXT        0
`define CIT_EV_RESET      1
`define CIT_EV_LOAD       2
`define CIT_EV_OVF        3
`define CIT_EV_XOP        4
`define CIT_EV_W          5

// ****************************************************************
// Status word fields seen from the processor
// ****************************************************************
`define CIT_ST_MASK_LO    12
`define CIT_ST_OVF_EN     10
`define CIT_ST_OVF        4

// ****************************************************************
// Trap vectors, workspace offsets, overflow level, load count and microprogram start
// ****************************************************************
`define CIT_VEC_RESET     16'h0000
`define CIT_VEC_LOAD      16'hfffc
`define CIT_VEC_INT_BASE  16'h0000
`define CIT_VEC_XOP_BASE  16'h0040
`define CIT_VEC_PC_OFS    16'h0002
`define CIT_WS_R13        16'h001a
`define CIT_WS_R14        16'h001c
`define CIT_WS_R15        16'h001e
`define CIT_OVF_LEVEL     4'h2
`define CIT_LOAD_COUNT    2'h2
`define CIT_UPC_START     12'h000

`endif

// file: cit_sync.v
`timescale 1ns/1ns

// ****************************************************************
// Two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module cit_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] stable_q;

   // First stage is read only by the second stage
   always @(posedge clk) begin
      if (!rst_n) begin
         meta_q   <= {W{1'b0}};
         stable_q <= {W{1'b0}};
      end else begin
         meta_q   <= async_in;
         stable_q <= meta_q;
      end
   end

   assign sync_out = stable_q;

endmodule

// file: cit_trap_unit.v
// How it works
// - Seventeen trap levels, fifteen maskable, two not
// - Fifteen bus lines, level zero ranks highest
// - Per-line enable bits; disabled lines ignored
// - Accept only when level code within mask
// - Level code is highest-priority enabled pending
// - Finish instruction, fetch 4*level, 4*level+2, switch
// - Reset switch: level 0, restart microprogram 000
// - Reset fetches 0000 and 0002, then switches
// - Reset trap abandons current instruction at once
// - Restart pulse or arm instruction raises load
// - Exactly two instructions run before load trap
// - Load trap vectors at FFFC and FFFE
// - Status bit 10 enables trap on bit 4
// - Overflow trap uses level two vectors
// - Overflow trap taken before next instruction
// - Interrupt vectors 0000-003F, extended ops 0040-007F
// - Return state saved in new R13-R15
`timescale 1ns/1ns
`include "cit_map.vh"

module cit_trap_unit (
   input  wire        CLK,
   input  wire        RST_N,
   input  wire        RESET_SW_N,
   input  wire [15:1] INT_REQ_N,
   input  wire        RESTART_N,
   input  wire        INSTR_DONE,
   input  wire        ARM_LOAD,
   input  wire        XOP_REQ,
   input  wire [3:0]  XOP_NUM,
   input  wire [15:0] STATUS_WORD,
   input  wire [15:0] CUR_WP,
   input  wire [15:0] CUR_PC,
   output reg         MEM_RD,
   output reg         MEM_WR,
   output reg  [15:0] MEM_ADDR,
   output reg  [15:0] MEM_WDATA,
   input  wire [15:0] MEM_RDATA,
   input  wire        MEM_ACK,
   output reg         CPU_HOLD,
   output reg         CPU_ABORT,
   output reg         UPC_START,
   output reg  [11:0] UPC_ADDR,
   output reg         CTX_LOAD,
   output reg  [15:0] CTX_WP,
   output reg  [15:0] CTX_PC,
   input  wire [3:0]  REG_ADDR,
   input  wire [15:0] REG_WDATA,
   input  wire        REG_WR,
   input  wire        REG_RD,
   output reg  [15:0] REG_RDATA,
   output wire        IRQ
);

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   localparam S_IDLE  = 3'h0;
   localparam S_HELD  = 3'h1;
   localparam S_FWP   = 3'h2;
   localparam S_FPC   = 3'h3;
   localparam S_SV13  = 3'h4;
   localparam S_SV14  = 3'h5;
   localparam S_SV15  = 3'h6;
   localparam S_LOAD  = 3'h7;

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Vector word address from a base and a level number
   function [15:0] vec_addr;
      input [15:0] base;
      input [3:0]  lvl;
      begin
         vec_addr = base + {10'h000, lvl, 2'b00};
      end
   endfunction

   // Lowest numbered active line wins
   function [4:0] prio_enc;
      input [15:0] req;
      integer i;
      begin
         prio_enc = 5'h10;
         for (i = 15; i >= 0; i = i - 1) begin
            if (req[i]) begin
               prio_enc = {1'b0, i[3:0]};
            end
         end
      end
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   wire [16:0] pins_s;

   cit_sync #(
      .W        (17)
   ) u_sync (
      .clk      (CLK),
      .rst_n    (RST_N),
      .async_in ({~RESTART_N, ~RESET_SW_N, ~INT_REQ_N}),
      .sync_out (pins_s)
   );

   wire [15:1] ext_req   = pins_s[14:0];
   wire        reset_sw  = pins_s[15];
   wire        restart   = pins_s[16];

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [14:0] enable_q;
   reg  [4:0]  event_q;
   reg  [4:0]  evmask_q;
   reg  [4:0]  ev_set;
   reg         restart_q;
   reg         reset_seen_q;
   reg         load_armed_q;
   reg  [1:0]  load_cnt_q;
   reg         load_due_q;
   reg  [15:0] vec_q;
   reg  [15:0] new_wp_q;
   reg  [15:0] old_wp_q;
   reg  [15:0] old_pc_q;
   reg  [15:0] old_st_q;
   reg  [3:0]  level_q;

   // ****************************************************************
   // Priority and masking
   // ****************************************************************
   // Overflow joins the level 2 request only while enabled
   wire        ovf_req = STATUS_WORD[`CIT_ST_OVF_EN]
                       & STATUS_WORD[`CIT_ST_OVF];
   reg  [15:0] lvl_req;
   always @* begin
      lvl_req                 = {ext_req & enable_q, 1'b0};
      lvl_req[`CIT_OVF_LEVEL] = lvl_req[`CIT_OVF_LEVEL]
                              | ovf_req;
   end

   wire [4:0] pend     = prio_enc(lvl_req);
   wire [3:0] pend_lvl = pend[3:0];
   wire [3:0] pri_mask = STATUS_WORD[`CIT_ST_MASK_LO+3:`CIT_ST_MASK_LO];
   // Level 0 is only the reset; bus lines never reach it
   wire       int_ok   = !pend[4] && (pend_lvl <= pri_mask);
   wire       ovf_win  = ovf_req && int_ok
                       && (pend_lvl == `CIT_OVF_LEVEL);
   wire       restart_rise = restart & ~restart_q;

   // ****************************************************************
   // Load trap arming and instruction counter
   // ****************************************************************
   // Counting stops once the trap is due so a late boundary can't skew it
   always @(posedge CLK) begin
      if (!RST_N) begin
         restart_q    <= 1'b0;
         load_armed_q <= 1'b0;
         load_cnt_q   <= 2'h0;
         load_due_q   <= 1'b0;
      end else begin
         restart_q <= restart;
         if (state_q == S_LOAD || reset_sw) begin
            load_armed_q <= 1'b0;
            load_due_q   <= 1'b0;
            load_cnt_q   <= 2'h0;
         end else if (restart_rise || ARM_LOAD) begin
            load_armed_q <= 1'b1;
            load_due_q   <= 1'b0;
            load_cnt_q   <= 2'h0;
         end else if (load_armed_q && !load_due_q && INSTR_DONE) begin
            load_cnt_q <= load_cnt_q + 2'h1;
            if (load_cnt_q + 2'h1 == `CIT_LOAD_COUNT) begin
               load_due_q <= 1'b1;
            end
         end
      end
   end

   // Load trap is taken at the boundary that ends the second one
   wire load_take = load_armed_q && !load_due_q && INSTR_DONE
                  && (load_cnt_q + 2'h1 == `CIT_LOAD_COUNT);

   // ****************************************************************
   // Trap sequencer
   // ****************************************************************
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (reset_sw) begin
               state_d = S_HELD;
            end else if (INSTR_DONE) begin
               if (load_take || int_ok || XOP_REQ) begin
                  state_d = S_FWP;
               end
            end
         end
         S_HELD: begin
            if (!reset_sw) begin
               state_d = S_FWP;
            end
         end
         S_FWP: begin
            if (MEM_ACK) begin
               state_d = S_FPC;
            end
         end
         S_FPC: begin
            if (MEM_ACK) begin
               state_d = S_SV13;
            end
         end
         S_SV13: begin
            if (MEM_ACK) begin
               state_d = S_SV14;
            end
         end
         S_SV14: begin
            if (MEM_ACK) begin
               state_d = S_SV15;
            end
         end
         S_SV15: begin
            if (MEM_ACK) begin
               state_d = S_LOAD;
            end
         end
         S_LOAD: begin
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
      // Reset switch overrides any sequence in progress
      if (reset_sw) begin
         state_d = S_HELD;
      end
   end

   // Trap selection, captured return state and vector words
   always @(posedge CLK) begin
      if (!RST_N) begin
         state_q      <= S_IDLE;
         vec_q        <= 16'h0000;
         new_wp_q     <= 16'h0000;
         old_wp_q     <= 16'h0000;
         old_pc_q     <= 16'h0000;
         old_st_q     <= 16'h0000;
         level_q      <= 4'h0;
         reset_seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == S_HELD) begin
            vec_q        <= `CIT_VEC_RESET;
            level_q      <= 4'h0;
            reset_seen_q <= 1'b1;
            old_wp_q     <= CUR_WP;
            old_pc_q     <= CUR_PC;
            old_st_q     <= STATUS_WORD;
         end else if (state_q == S_IDLE && state_d == S_FWP) begin
            reset_seen_q <= 1'b0;
            old_wp_q     <= CUR_WP;
            old_pc_q     <= CUR_PC;
            old_st_q     <= STATUS_WORD;
            // Non-maskable load ranks above any maskable level
            if (load_take) begin
               vec_q <= `CIT_VEC_LOAD;
            end else if (int_ok) begin
               vec_q   <= vec_addr(`CIT_VEC_INT_BASE, pend_lvl);
               level_q <= pend_lvl;
            end else begin
               vec_q <= vec_addr(`CIT_VEC_XOP_BASE, XOP_NUM);
            end
         end
         if (state_q == S_FWP && MEM_ACK) begin
            new_wp_q <= MEM_RDATA;
         end
      end
   end

   // Vector of the trap being entered this cycle from idle
   wire [15:0] next_vec = load_take ? `CIT_VEC_LOAD
                        : int_ok ? vec_addr(`CIT_VEC_INT_BASE, pend_lvl)
                        : vec_addr(`CIT_VEC_XOP_BASE, XOP_NUM);

   // ****************************************************************
   // Memory cycles and control outputs
   // ****************************************************************
   // Strobes stay up until the memory acknowledges each word
   always @(posedge CLK) begin
      if (!RST_N) begin
         MEM_RD    <= 1'b0;
         MEM_WR    <= 1'b0;
         MEM_ADDR  <= 16'h0000;
         MEM_WDATA <= 16'h0000;
         CPU_HOLD  <= 1'b0;
         CPU_ABORT <= 1'b0;
         UPC_START <= 1'b0;
         UPC_ADDR  <= `CIT_UPC_START;
         CTX_LOAD  <= 1'b0;
         CTX_WP    <= 16'h0000;
         CTX_PC    <= 16'h0000;
      end else begin
         CPU_HOLD  <= (state_d != S_IDLE);
         // Abort stands for as long as the switch is held down
         CPU_ABORT <= reset_sw;
         UPC_START <= (state_q == S_HELD) && !reset_sw;
         UPC_ADDR  <= `CIT_UPC_START;
         CTX_LOAD  <= 1'b0;
         MEM_RD    <= 1'b0;
         MEM_WR    <= 1'b0;
         case (state_d)
            S_FWP: begin
               MEM_RD   <= 1'b1;
               MEM_ADDR <= (state_q == S_HELD) ? `CIT_VEC_RESET
                         : (state_q == S_IDLE) ? next_vec : vec_q;
            end
            S_FPC: begin
               MEM_RD   <= 1'b1;
               MEM_ADDR <= vec_q + `CIT_VEC_PC_OFS;
            end
            S_SV13: begin
               MEM_WR    <= 1'b1;
               MEM_ADDR  <= new_wp_q + `CIT_WS_R13;
               MEM_WDATA <= old_wp_q;
            end
            S_SV14: begin
               MEM_WR    <= 1'b1;
               MEM_ADDR  <= new_wp_q + `CIT_WS_R14;
               MEM_WDATA <= old_pc_q;
            end
            S_SV15: begin
               MEM_WR    <= 1'b1;
               MEM_ADDR  <= new_wp_q + `CIT_WS_R15;
               MEM_WDATA <= old_st_q;
            end
            default: begin
               MEM_ADDR <= MEM_ADDR;
            end
         endcase
         if (state_q == S_FPC && MEM_ACK) begin
            CTX_PC <= MEM_RDATA;
         end
         if (state_q == S_LOAD) begin
            CTX_LOAD <= 1'b1;
            CTX_WP   <= new_wp_q;
         end
      end
   end

   // ****************************************************************
   // Event status, mask and interrupt
   // ****************************************************************
   always @* begin
      ev_set = 5'h00;
      if (state_q == S_LOAD) begin
         if (reset_seen_q) begin
            ev_set[`CIT_EV_RESET] = 1'b1;
         end else if (vec_q == `CIT_VEC_LOAD) begin
            ev_set[`CIT_EV_LOAD] = 1'b1;
         end else if (vec_q >= `CIT_VEC_XOP_BASE) begin
            ev_set[`CIT_EV_XOP] = 1'b1;
         end else begin
            ev_set[`CIT_EV_EXT] = 1'b1;
         end
      end
      // Overflow trap is flagged as it is chosen at the boundary
      if (state_q == S_IDLE && state_d == S_FWP && !load_take
          && ovf_win) begin
         ev_set[`CIT_EV_OVF] = 1'b1;
      end
   end

   // Write-one-to-clear; a new event in the same cycle stays set
   always @(posedge CLK) begin
      if (!RST_N) begin
         enable_q <= `CIT_ENABLE_RST;
         evmask_q <= `CIT_EVMASK_RST;
         event_q  <= 5'h00;
      end else begin
         if (REG_WR && REG_ADDR == `CIT_REG_ENABLE) begin
            enable_q <= REG_WDATA[15:1];
         end
         if (REG_WR && REG_ADDR == `CIT_REG_EVMASK) begin
            evmask_q <= REG_WDATA[`CIT_EV_W-1:0];
         end
         if (REG_WR && REG_ADDR == `CIT_REG_EVENT) begin
            event_q <= (event_q & ~REG_WDATA[`CIT_EV_W-1:0]) | ev_set;
         end else begin
            event_q <= event_q | ev_set;
         end
      end
   end

   assign IRQ = |(event_q & evmask_q);

   // ****************************************************************
   // Register read port
   // ****************************************************************
   // Unmapped addresses read as zero
   always @(posedge CLK) begin
      if (!RST_N) begin
         REG_RDATA <= 16'h0000;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `CIT_REG_ENABLE: REG_RDATA <= {enable_q, 1'b0};
            `CIT_REG_EVENT:  REG_RDATA <= {11'h000, event_q};
            `CIT_REG_EVMASK: REG_RDATA <= {11'h000, evmask_q};
            `CIT_REG_STATE:  REG_RDATA <= {pend, level_q, state_q,
                                           load_armed_q, load_cnt_q,
                                           1'b0};
            default:         REG_RDATA <= 16'h0000;
         endcase
      end else begin
         REG_RDATA <= 16'h0000;
      end
   end

endmodule

// file: cit_chk.sv
`timescale 1ns/1ns

// ****************************************************************
// Port checker for the trap sequencer
// ****************************************************************
module cit_chk (
   input wire        CLK,
   input wire        RST_N,
   input wire [15:0] CUR_WP,
   input wire        MEM_RD,
   input wire        MEM_WR,
   input wire [15:0] MEM_ADDR,
   input wire [15:0] MEM_WDATA,
   input wire [15:0] MEM_RDATA,
   input wire        MEM_ACK,
   input wire        CPU_HOLD,
   input wire        CPU_ABORT,
   input wire        UPC_START,
   input wire [11:0] UPC_ADDR,
   input wire        CTX_LOAD,
   input wire [15:0] CTX_WP,
   input wire [15:0] CTX_PC
);
   reg [15:0] va_q;
   reg [15:0] wp_q;
   reg [15:0] pc_q;

   // Vector words as fetched; held until the next trap overwrites them
   always @(posedge CLK) begin
      if (MEM_RD && MEM_ACK && !MEM_ADDR[1]) begin
         va_q <= MEM_ADDR;
         wp_q <= MEM_RDATA;
      end
      if (MEM_RD && MEM_ACK && MEM_ADDR[1])
         pc_q <= MEM_RDATA;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // WP word sits on a multiple of four, PC word two above it
   sequence s_wp_read;
      MEM_RD && MEM_ACK && !MEM_ADDR[1];
   endsequence
   sequence s_pc_read;
      MEM_RD && MEM_ACK && MEM_ADDR[1];
   endsequence

   a_abort_holds: assert property (CPU_ABORT |-> CPU_HOLD)
      else $error("abort without hold");
   a_upc_zero: assert property (UPC_ADDR == 12'h000)
      else $error("restart address not zero");
   a_upc_pulse: assert property (UPC_START |=> !UPC_START)
      else $error("restart pulse too long");
   a_upc_fetch: assert property (
      UPC_START |-> ##[0:4] (MEM_RD && MEM_ADDR == 16'h0000))
      else $error("no reset vector fetch");
   a_rd_holds: assert property (
      MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR))
      else $error("read dropped before ack");
   a_pc_follows: assert property (
      s_wp_read |=> ##[0:3] (MEM_RD && MEM_ADDR == va_q + 16'h0002))
      else $error("pc word not fetched after wp");
   a_r13_save: assert property (
      s_pc_read |=> ##[0:3] (MEM_WR && MEM_ADDR == wp_q + 16'h001a
                             && MEM_WDATA == CUR_WP))
      else $error("old wp not saved in new r13");
   a_r14_next: assert property (
      MEM_WR && MEM_ACK && MEM_ADDR == wp_q + 16'h001a
      |=> ##[0:3] (MEM_WR && MEM_ADDR == wp_q + 16'h001c))
      else $error("r14 save does not follow r13");
   a_ctx_pulse: assert property (CTX_LOAD |=> !CTX_LOAD)
      else $error("context load too long");
   a_ctx_words: assert property (
      CTX_LOAD |-> CTX_WP == wp_q && CTX_PC == pc_q)
      else $error("context differs from vector");
endmodule

// file: cit_mem.sv
`timescale 1ns/1ns

// ****************************************************************
// Memory model answering the sequencer's word cycles
// ****************************************************************
module cit_mem (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        rd,
   input  wire        wr,
   input  wire [15:0] addr,
   output wire [15:0] rdata,
   output reg         ack
);
   reg [1:0] cnt_q;
   reg [1:0] lat_q;

   // Outside the ack cycle the bus shows the inverse, never a stale word
   assign rdata = ack ? (addr ^ 16'h5a00) : ~(addr ^ 16'h5a00);

   // Latency cycles 0, 3, 2, 1 so prompt and slow answers both occur
   always @(posedge clk) begin
      if (!rst_n) begin
         ack   <= 1'b0;
         cnt_q <= 2'h0;
         lat_q <= 2'h0;
      end else if (ack) begin
         ack   <= 1'b0;
         cnt_q <= 2'h0;
         lat_q <= lat_q + 2'h3;
      end else if ((rd || wr) && cnt_q == lat_q) begin
         ack <= 1'b1;
      end else if (rd || wr) begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
endmodule

// file: tb.sv
`timescale 1ns/1ns
`include "cit_map.vh"

bind cit_trap_unit cit_chk u_cit_chk (
   .CLK(CLK), .RST_N(RST_N), .CUR_WP(CUR_WP), .MEM_RD(MEM_RD),
   .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
   .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .CPU_HOLD(CPU_HOLD),
   .CPU_ABORT(CPU_ABORT), .UPC_START(UPC_START), .UPC_ADDR(UPC_ADDR),
   .CTX_LOAD(CTX_LOAD), .CTX_WP(CTX_WP), .CTX_PC(CTX_PC));

// ****************************************************************
// Self-checking bench for the trap sequencer
// ****************************************************************
module tb;
   reg         clk, rst_n, rsw_n, rln, done, arm, xreq, rwr, rrd;
   reg  [15:1] irq_n;
   reg  [3:0]  xnum, ra;
   reg  [15:0] st, cwp, cpc, rwd;
   reg  [31:0] r;
   wire        mrd, mwr, mack, hold, abort, upcs, ctxl, irq;
   wire [15:0] ma, mwd, mrdat, nwp, npc, rrdat;
   wire [11:0] upca;
   integer     seed, fails, comparisons, i, lvl, lv2, ups;

   cit_trap_unit u_cit_trap_unit (
      .CLK(clk), .RST_N(rst_n), .RESET_SW_N(rsw_n), .INT_REQ_N(irq_n),
      .RESTART_N(rln), .INSTR_DONE(done), .ARM_LOAD(arm), .XOP_REQ(xreq),
      .XOP_NUM(xnum), .STATUS_WORD(st), .CUR_WP(cwp), .CUR_PC(cpc),
      .MEM_RD(mrd), .MEM_WR(mwr), .MEM_ADDR(ma), .MEM_WDATA(mwd),
      .MEM_RDATA(mrdat), .MEM_ACK(mack), .CPU_HOLD(hold),
      .CPU_ABORT(abort), .UPC_START(upcs), .UPC_ADDR(upca),
      .CTX_LOAD(ctxl), .CTX_WP(nwp), .CTX_PC(npc), .REG_ADDR(ra),
      .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rrdat),
      .IRQ(irq));
   cit_mem u_cit_mem (.clk(clk), .rst_n(rst_n), .rd(mrd), .wr(mwr),
      .addr(ma), .rdata(mrdat), .ack(mack));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Vector address of a level; extended ops follow the 16 pairs
   function [15:0] tvec(input integer l);
      tvec = {l[13:0], 2'b00};
   endfunction

   task chk(input string name, input [15:0] seen, input [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task close_out;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask

   task wr(input [3:0] a, input [15:0] d);
      @(posedge clk);
      ra <= a;
      rwd <= d;
      rwr <= 1'b1;
      @(posedge clk);
      rwr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input string n, input [3:0] a, input [15:0] exp);
      @(posedge clk);
      ra <= a;
      rrd <= 1'b1;
      @(posedge clk);
      rrd <= 1'b0;
      #1 chk(n, rrdat, exp);
   endtask

   // Optional boundary pulse, then follow the fetch up to the switch
   task trap(input pul, input want, input [15:0] vec);
      reg [15:0] first;
      integer    n, rds, got;
      rds = 0;
      got = 0;
      ups = 0;
      if (pul) begin
         @(posedge clk);
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
      end
      for (n = 0; n < 40 && got == 0; n = n + 1) begin
         @(posedge clk);
         #1;
         if (mrd && rds == 0)
            first = ma;
         rds = rds + mrd;
         ups = ups + upcs;
         got = ctxl;
      end
      if (!want)
         chk("no trap", rds[15:0], 16'h0000);
      else if (got == 0) begin
         fails = fails + 1;
         close_out;
      end else begin
         chk("vector", first, vec);
         chk("new wp", nwp, vec ^ 16'h5a00);
         chk("new pc", npc, (vec + 16'h0002) ^ 16'h5a00);
      end
   endtask

   initial begin
      seed = 65954;
      fails = 0;
      comparisons = 0;
      {rst_n, done, arm, xreq, rwr, rrd} = 6'h00;
      {rsw_n, rln} = 2'h3;
      irq_n = 15'h7fff;
      {xnum, ra, st, rwd} = 40'h0;
      cwp = 16'h1234;
      cpc = 16'h4000;
      cyc(5);
      rst_n <= 1'b1;
      rd("enable", `CIT_REG_ENABLE, `CIT_ENABLE_RST);
      rd("unmapped", 4'h9, 16'h0000);
      wr(`CIT_REG_ENABLE, 16'hffff);
      rd("enable", `CIT_REG_ENABLE, 16'hfffe);
      $display("test registers done");
      // Random lines and pairs; the lower number must win
      st <= 16'hf000;
      for (i = 0; i < 12; i = i + 1) begin
         r = $random(seed);
         lvl = 1 + {$random(seed)} % 15;
         lv2 = (i < 4) ? lvl : 1 + {$random(seed)} % 15;
         irq_n <= ~((15'h1 << (lvl - 1)) | (15'h1 << (lv2 - 1)));
         cwp <= r[15:0];
         cpc <= r[31:16];
         cyc(4);
         trap(1, 1, tvec(lvl < lv2 ? lvl : lv2));
         irq_n <= 15'h7fff;
         cyc(4);
      end
      // Level equal to the mask is taken, one above is not
      irq_n <= 15'h7fef;
      st <= 16'h4000;
      cyc(4);
      trap(1, 0, 16'h0000);
      st <= 16'h5000;
      trap(1, 1, 16'h0014);
      wr(`CIT_REG_ENABLE, 16'hffde);
      trap(1, 0, 16'h0000);
      irq_n <= 15'h7fff;
      $display("test bus lines done");
      // Overflow goes to level two only with its enable set
      st <= 16'hf010;
      trap(1, 0, 16'h0000);
      st <= 16'hf410;
      trap(1, 1, 16'h0008);
      st <= 16'hf000;
      $display("test overflow done");
      // Arm by instruction, then by restart pulse; two more run first
      for (i = 0; i < 2; i = i + 1) begin
         @(posedge clk);
         arm <= (i == 0);
         rln <= (i == 0);
         @(posedge clk);
         arm <= 1'b0;
         cyc(2);
         rln <= 1'b1;
         cyc(4);
         trap(1, 0, 16'h0000);
         trap(1, 1, 16'hfffc);
      end
      $display("test load done");
      // Every extended operation number lands in the upper block
      xreq <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
         xnum <= i[3:0];
         trap(1, 1, tvec(16 + i));
      end
      xreq <= 1'b0;
      $display("test extended ops done");
      // Event flag: raise, hold masked, unmask, clear
      wr(`CIT_REG_EVENT, 16'h001f);
      wr(`CIT_REG_EVMASK, 16'h0000);
      rd("event", `CIT_REG_EVENT, 16'h0000);
      xreq <= 1'b1;
      xnum <= 4'h2;
      trap(1, 1, tvec(18));
      xreq <= 1'b0;
      rd("event", `CIT_REG_EVENT, 16'h1 << `CIT_EV_XOP);
      chk("irq masked", irq, 16'h0000);
      wr(`CIT_REG_EVMASK, 16'h1 << `CIT_EV_XOP);
      #1 chk("irq", irq, 16'h0001);
      wr(`CIT_REG_EVENT, 16'h1 << `CIT_EV_XOP);
      #1 chk("irq cleared", irq, 16'h0000);
      $display("test events done");
      // Switch is seen only after the synchroniser, then aborts at once
      rsw_n <= 1'b0;
      cyc(1);
      #1 chk("abort early", abort, 16'h0000);
      cyc(3);
      #1 chk("abort", abort, 16'h0001);
      chk("hold", hold, 16'h0001);
      rsw_n <= 1'b1;
      trap(0, 1, `CIT_VEC_RESET);
      chk("restart", ups[15:0], 16'h0001);
      $display("test reset switch done");
      // Second reset in mid-run clears the line enables
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      rd("enable", `CIT_REG_ENABLE, `CIT_ENABLE_RST);
      $display("test second reset done");
      close_out;
   end
endmodule
